/* File: hw/coordinate_store_and_accu_calc.sv */
// Command interpreter for the coordinate table and accumulator/X arithmetic
// What this block does
// - Get-coordinate with motor 255, entry 0 reloads entries 1..20 from storage.
// - Get-coordinate with motor 255, entry 1..20 reloads only that entry.
// - Capture-coordinate, code 32, stores actual axis position into the entry.
// - The store_nv_i strap chooses RAM only or also storage commit; low means RAM only.
// - Entry zero is never committed to storage.
// - Capture-coordinate replies status 100 carrying the captured value.
// - Accu-to-coordinate, code 39, writes the accumulator into the entry.
// - Calc-with-X, code 33, combines accumulator and X, result to accumulator.
// - Types 0..7: add, sub, mul, div, modulo, and, or, xor.
// - Type 8 inverts the X register.
// - Type 9 copies accumulator to X; type 10 swaps them.
// - Accu-to-axis-parameter writes accumulator to the selected axis parameter.
// - Get-coordinate loads accumulator standalone, replies value only in direct mode.
// - Accu-to-axis-parameter is code 34, replies 100.
`timescale 1ns/1ps
`default_nettype none
`include "coord_cfg.svh"
module coordinate_store_and_accu_calc
	import coord_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	input  wire logic        byte_valid_i,
	input  wire logic [7:0]  byte_data_i,
	input  wire logic        standalone_i,
	input  wire logic [31:0] actual_pos_i,
	input  wire logic        store_nv_i,
	input  wire logic        nv_ack_i,
	input  wire logic [31:0] nv_rdata_i,
	output logic             reply_valid_o,
	output logic [7:0]       reply_status_o,
	output logic [7:0]       reply_instr_o,
	output logic [31:0]      reply_value_o,
	output logic             nv_req_o,
	output logic             nv_write_o,
	output logic [4:0]       nv_index_o,
	output logic [31:0]      nv_wdata_o,
	output logic             axis_wr_o,
	output logic [7:0]       axis_param_o,
	output logic [31:0]      axis_data_o,
	output logic [31:0]      accu_o
);

	////////////////////////////////////////////////////////////////////////////
	typedef logic [31:0] table_t [0:20];

	typedef struct packed {
		state_e      state;
		logic [3:0]  count;
		logic [7:0]  sum;
		logic [63:0] shift;
		frame_s      frame;
		logic [31:0] accu;
		logic [31:0] xreg;
		logic [4:0]  nv_idx;
		logic [4:0]  nv_end;
		reply_s      reply;
		nv_req_s     nv;
		axis_wr_s    axis;
	} core_s;

	core_s core_reg;
	core_s core_next;
	table_t table_reg;
	table_t table_next;
	logic store_meta_reg;
	logic store_nv_reg;

	// A zero divisor leaves the accumulator as it was instead of trapping
	function automatic logic div_ok(input logic [31:0] b);
		div_ok = (b != 32'h0);
	endfunction

	function automatic logic [31:0] alu(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b);
		logic signed [31:0] sa;
		logic signed [31:0] sb;
		sa = a;
		sb = b;
		unique case (op)
			4'h0: alu = a + b;
			4'h1: alu = a - b;
			4'h2: alu = 32'(sa * sb);
			4'h3: alu = div_ok(b) ? 32'(sa / sb) : a;
			4'h4: alu = div_ok(b) ? 32'(sa % sb) : a;
			4'h5: alu = a & b;
			4'h6: alu = a | b;
			4'h7: alu = a ^ b;
			default: alu = a;
		endcase
	endfunction

	function automatic logic coord_ok(input logic [7:0] t);
		coord_ok = (t <= {3'h0, `COORD_LAST});
	endfunction

	// Every answer is built the same way, so its fields cannot drift apart
	function automatic reply_s make_reply(input logic [7:0] status, input logic [7:0] instr, input logic [31:0] value);
		make_reply.valid  = 1'b1;
		make_reply.status = status;
		make_reply.instr  = instr;
		make_reply.value  = value;
	endfunction

	function automatic nv_req_s make_nv(input logic write, input logic [4:0] index, input logic [31:0] data);
		make_nv.req   = 1'b1;
		make_nv.write = write;
		make_nv.index = index;
		make_nv.data  = data;
	endfunction

	// Instruction is the second of the eight bytes shifted in
	function automatic logic [7:0] shifted_instr(input logic [63:0] s);
		shifted_instr = s[`SHIFT_INSTR_MSB -: 8];
	endfunction

	////////////////////////////////////////////////////////////////////////////
	logic [4:0] entry_idx;
	logic       entry_ok;
	logic       entry_zero;
	logic       bank_nv;
	logic       is_set;
	logic       is_capture;
	logic       is_accu_coord;
	logic       sum_good;

	assign entry_idx     = core_reg.frame.typ[4:0];
	assign entry_ok      = coord_ok(core_reg.frame.typ);
	assign entry_zero    = (core_reg.frame.typ == `ENTRY_ZERO);
	assign bank_nv       = (core_reg.frame.motor == `NV_BANK);
	assign is_set        = (core_reg.frame.instr == `OP_SET_COORD);
	assign is_capture    = (core_reg.frame.instr == `OP_CAPTURE_COORD);
	assign is_accu_coord = (core_reg.frame.instr == `OP_ACCU_COORD);
	assign sum_good      = (byte_data_i == core_reg.sum);

	////////////////////////////////////////////////////////////////////////////
	// Strap level crosses in through two flops; it selects storage commit
	always_ff @(posedge clock_i) begin
		store_meta_reg <= store_nv_i;
		store_nv_reg   <= store_meta_reg;
	end

	always_comb begin
		logic [7:0]  b;
		logic [7:0]  ix;
		logic        commit;
		logic [31:0] newval;
		b          = byte_data_i;
		ix         = core_reg.frame.typ;
		commit     = 1'b0;
		newval     = 32'h0;
		core_next  = core_reg;
		table_next = table_reg;
		core_next.reply.valid = 1'b0;
		core_next.axis.valid  = 1'b0;
		unique case (core_reg.state)
			ST_RECV: begin
				if (byte_valid_i) begin
					if (core_reg.count == `FRAME_LAST) begin
						core_next.count = 4'h0;
						core_next.sum   = 8'h0;
						core_next.frame = core_reg.shift;
						if (sum_good) begin
							core_next.state = ST_EXEC;
						end else begin
							core_next.reply = make_reply(`STATUS_BAD_SUM, shifted_instr(core_reg.shift), 32'h0);
						end
					end else begin
						core_next.count = core_reg.count + 4'h1;
						core_next.sum   = core_reg.sum + b;
						core_next.shift = {core_reg.shift[55:0], b};
					end
				end
			end
			ST_EXEC: begin
				core_next.state = ST_RECV;
				core_next.reply = make_reply(`STATUS_OK, core_reg.frame.instr, 32'h0);
				unique case (core_reg.frame.instr)
					`OP_SET_COORD, `OP_CAPTURE_COORD, `OP_ACCU_COORD: begin
						if (!entry_ok) begin
							core_next.reply.status = `STATUS_BAD_TYPE;
						end else if (is_set && bank_nv) begin
							core_next.reply.status = `STATUS_BAD_VAL;
						end else begin
							newval = core_reg.frame.value;
							if (is_capture) begin
								newval = actual_pos_i;
								core_next.reply.value = actual_pos_i;
							end
							if (is_accu_coord) begin
								newval = core_reg.accu;
							end
							table_next[entry_idx] = newval;
							// Entry zero never reaches storage, whatever the setting
							commit = store_nv_reg && !entry_zero;
						end
					end
					`OP_GET_COORD: begin
						if (!entry_ok) begin
							core_next.reply.status = `STATUS_BAD_TYPE;
						end else if (bank_nv) begin
							core_next.state       = ST_NVLOAD;
							core_next.reply.valid = 1'b0;
							core_next.nv          = make_nv(1'b0, entry_zero ? `COORD_FIRST : entry_idx, 32'h0);
							core_next.nv_end      = entry_zero ? `COORD_LAST : entry_idx;
						end else if (standalone_i) begin
							core_next.accu = table_reg[entry_idx];
						end else begin
							core_next.reply.value = table_reg[entry_idx];
						end
					end
					`OP_CALC_X: begin
						unique case (ix)
							`CALC_NOT: begin
								core_next.xreg = ~core_reg.xreg;
							end
							`CALC_LOAD: begin
								core_next.xreg = core_reg.accu;
							end
							`CALC_SWAP: begin
								core_next.xreg = core_reg.accu;
								core_next.accu = core_reg.xreg;
							end
							default: begin
								if (ix < `CALC_NOT) begin
									core_next.accu = alu(ix[3:0], core_reg.accu, core_reg.xreg);
								end else begin
									core_next.reply.status = `STATUS_BAD_TYPE;
								end
							end
						endcase
					end
					`OP_ACCU_AXIS: begin
						core_next.axis = '{1'b1, ix, core_reg.accu};
					end
					default: core_next.reply.status = `STATUS_BAD_CMD;
				endcase
				if (commit) begin
					core_next.state       = ST_NVSAVE;
					core_next.reply.valid = 1'b0;
					core_next.nv          = make_nv(1'b1, entry_idx, newval);
				end
			end
			ST_NVLOAD: begin
				// One entry per acknowledge; the request stays up for the whole walk
				if (nv_ack_i) begin
					table_next[core_reg.nv.index] = nv_rdata_i;
					if (core_reg.nv.index == core_reg.nv_end) begin
						core_next.nv.req = 1'b0;
						core_next.state  = ST_RECV;
						core_next.reply  = make_reply(`STATUS_OK, core_reg.frame.instr, 32'h0);
					end else begin
						core_next.nv.index = core_reg.nv.index + 5'h1;
					end
				end
			end
			ST_NVSAVE: begin
				if (nv_ack_i) begin
					core_next.nv.req = 1'b0;
					core_next.state  = ST_RECV;
					core_next.reply  = make_reply(`STATUS_OK, core_reg.frame.instr, core_reg.reply.value);
				end
			end
			default: core_next.state = ST_RECV;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Table has no reset so it maps to plain storage; entries start unknown
	always_ff @(posedge clock_i) begin
		table_reg <= table_next;
		if (rst_i) begin
			core_reg       <= '0;
			core_reg.state <= ST_RECV;
		end else begin
			core_reg <= core_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs are plain views of registered state, so none of them glitches
	assign reply_valid_o  = core_reg.reply.valid;
	assign reply_status_o = core_reg.reply.status;
	assign reply_instr_o  = core_reg.reply.instr;
	assign reply_value_o  = core_reg.reply.value;
	assign nv_req_o       = core_reg.nv.req;
	assign nv_write_o     = core_reg.nv.write;
	assign nv_index_o     = core_reg.nv.index;
	assign nv_wdata_o     = core_reg.nv.data;
	assign axis_wr_o      = core_reg.axis.valid;
	assign axis_param_o   = core_reg.axis.param;
	assign axis_data_o    = core_reg.axis.data;
	assign accu_o         = core_reg.accu;

endmodule
`default_nettype wire

/* File: hw/coord_cfg.svh */
// Constants for the coordinate store and accumulator calculator
`ifndef COORD_CFG_SVH
`define COORD_CFG_SVH
`define OP_GET_COORD     8'h1F
`define OP_CAPTURE_COORD 8'h20
`define OP_CALC_X        8'h21
`define OP_ACCU_AXIS     8'h22
`define OP_ACCU_COORD    8'h27
`define OP_SET_COORD     8'h1E
`define NV_BANK          8'hFF
`define COORD_LAST       5'h14
`define STATUS_OK        8'h64
`define STATUS_BAD_SUM   8'h01
`define STATUS_BAD_CMD   8'h02
`define STATUS_BAD_TYPE  8'h03
`define STATUS_BAD_VAL   8'h04
`define GP_STORE_NV      8'h54
`define FRAME_LAST       4'h8
`define CALC_NOT         8'h08
`define CALC_LOAD        8'h09
`define CALC_SWAP        8'h0A
`define COORD_FIRST      5'h01
`define ENTRY_ZERO       8'h00
`define SHIFT_INSTR_MSB  55
`endif

/* File: hw/coord_pkg.sv */
// Types for the coordinate store and accumulator calculator
`default_nettype none
package coord_pkg;
	typedef enum logic [3:0] {
		ST_RECV   = 4'b0001,
		ST_EXEC   = 4'b0010,
		ST_NVLOAD = 4'b0100,
		ST_NVSAVE = 4'b1000
	} state_e;

	typedef struct packed {
		logic [7:0]  addr;
		logic [7:0]  instr;
		logic [7:0]  typ;
		logic [7:0]  motor;
		logic [31:0] value;
	} frame_s;

	typedef struct packed {
		logic        valid;
		logic [7:0]  status;
		logic [7:0]  instr;
		logic [31:0] value;
	} reply_s;

	typedef struct packed {
		logic        req;
		logic        write;
		logic [4:0]  index;
		logic [31:0] data;
	} nv_req_s;

	typedef struct packed {
		logic        valid;
		logic [7:0]  param;
		logic [31:0] data;
	} axis_wr_s;
endpackage
`default_nettype wire

/* File: testbench/coord_props.sv */
// Checker for the coordinate store and accumulator calculator
`timescale 1ns/1ps
`default_nettype none
module coord_props (
	input wire logic        clock_i,
	input wire logic        rst_i,
	input wire logic        store_nv_i,
	input wire logic        standalone_i,
	input wire logic [31:0] actual_pos_i,
	input wire logic        reply_valid_o,
	input wire logic [7:0]  reply_status_o,
	input wire logic [7:0]  reply_instr_o,
	input wire logic [31:0] reply_value_o,
	input wire logic        nv_req_o,
	input wire logic        nv_write_o,
	input wire logic [4:0]  nv_index_o,
	input wire logic        axis_wr_o,
	input wire logic [31:0] axis_data_o,
	input wire logic [31:0] accu_o
);
default clocking @(posedge clock_i); endclocking
default disable iff (rst_i);
a_reply_pulse: assert property (
	reply_valid_o |=> !reply_valid_o) else $error("reply pulse");
a_axis_with_reply: assert property (
	axis_wr_o |-> reply_valid_o && reply_instr_o == 8'h22 && reply_status_o == 8'h64) else $error("axis reply");
a_axis_accu: assert property (
	axis_wr_o |-> axis_data_o == accu_o && $stable(accu_o)) else $error("axis data");
a_nv_no_zero: assert property (
	nv_req_o && nv_write_o |-> nv_index_o != 5'h00) else $error("entry zero stored");
a_nv_ram_only: assert property (
	nv_req_o && nv_write_o |-> store_nv_i) else $error("commit while ram only");
a_nv_range: assert property (
	nv_req_o |-> nv_index_o <= 5'h14) else $error("entry range");
a_capture_value: assert property (
	reply_valid_o && reply_instr_o == 8'h20 && reply_status_o == 8'h64 |-> reply_value_o == actual_pos_i)
	else $error("capture value");
a_get_direct: assert property (
	reply_valid_o && reply_instr_o == 8'h1F && !standalone_i |-> $stable(accu_o)) else $error("accu touched");
endmodule
bind coordinate_store_and_accu_calc coord_props i_coord_props (.*);
`default_nettype wire

/* File: testbench/nv_store_model.sv */
// Storage model answering the block's storage requests
`timescale 1ns/1ps
`default_nettype none
module nv_store_model (
	input  wire logic        clock_i,
	input  wire logic        req_i,
	input  wire logic        write_i,
	input  wire logic [4:0]  index_i,
	input  wire logic [31:0] wdata_i,
	output var  logic        ack_o,
	output var  logic [31:0] rdata_o
);
logic [31:0] mem [32];
logic [1:0]  cnt = 2'h0;
initial for (int i = 0; i < 32; i++) mem[i] = 32'hA5000000 + i;
// Delay of 0..3 cycles follows the index, so prompt and slow answers mix
always @(posedge clock_i) begin
	ack_o <= 1'b0;
	rdata_o <= ~mem[index_i];
	cnt <= cnt + 2'h1;
	if (req_i && !ack_o && cnt == index_i[1:0]) begin
		ack_o <= 1'b1;
		cnt <= 2'h0;
		rdata_o <= mem[index_i];
		if (write_i) mem[index_i] <= wdata_i;
	end
end
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench for the coordinate store and accumulator calculator
`timescale 1ns/1ps
`default_nettype none
module tb import coord_pkg::*;;
logic clock_i = 0, rst_i = 1, byte_valid_i = 0, standalone_i = 0, store_nv_i = 0;
logic nv_ack_i, reply_valid_o, nv_req_o, nv_write_o, axis_wr_o, aw;
logic [7:0] byte_data_i = 0, reply_status_o, reply_instr_o, axis_param_o, ap;
logic [4:0] nv_index_o;
logic [31:0] actual_pos_i = 0, nv_rdata_i, reply_value_o, nv_wdata_o, axis_data_o, accu_o;
logic [31:0] seed = 32'h85D88E21, v, p, a, x;
logic [63:0] e;
int bad_count = 0, comparisons = 0;
reply_s rr;
always #50 clock_i = ~clock_i;
coordinate_store_and_accu_calc i_coordinate_store_and_accu_calc (.*);
nv_store_model i_nv_store_model (.clock_i, .req_i(nv_req_o), .write_i(nv_write_o),
	.index_i(nv_index_o), .wdata_i(nv_wdata_o), .ack_o(nv_ack_i), .rdata_o(nv_rdata_i));
function automatic logic [31:0] rnd();
	seed ^= seed << 13;
	seed ^= seed >> 17;
	seed ^= seed << 5;
	return seed;
endfunction
function automatic logic [63:0] calc(input int t, input logic [31:0] a, x);
	case (t)
	0: return {a + x, x};
	1: return {a - x, x};
	2: return {a * x, x};
	3: return {$signed(a) / $signed(x), x};
	4: return {$signed(a) % $signed(x), x};
	5: return {a & x, x};
	6: return {a | x, x};
	7: return {a ^ x, x};
	8: return {a, ~x};
	9: return {a, a};
	default: return {x, a};
	endcase
endfunction
task automatic chk(input logic [31:0] got, exp);
	comparisons++;
	if (got !== exp) begin
		bad_count++;
		$display("unexpected at %0t: got %h want %h", $time, got, exp);
	end
endtask
task automatic send(input logic [7:0] ins, typ, mot, input logic [31:0] d, input logic [7:0] sk = 8'h00);
	logic [7:0] b [9];
	int n;
	b = '{8'h01, ins, typ, mot, d[31:24], d[23:16], d[15:8], d[7:0], sk};
	n = 0;
	for (int i = 0; i < 8; i++) b[8] += b[i];
	foreach (b[i]) begin
		@(posedge clock_i);
		byte_valid_i <= 1'b1;
		byte_data_i <= b[i];
	end
	@(posedge clock_i);
	byte_valid_i <= 1'b0;
	do begin
		@(negedge clock_i);
		n++;
	end while (reply_valid_o !== 1'b1 && n < 300);
	if (n >= 300) begin
		bad_count++;
		$display("unexpected at %0t: no reply", $time);
		finish_test();
	end
	rr = {reply_valid_o, reply_status_o, reply_instr_o, reply_value_o};
	aw = axis_wr_o;
	ap = axis_param_o;
	@(posedge clock_i);
endtask
task automatic lda(input logic [31:0] d);
	send(8'h1E, 8'h02, 8'h00, d);
	standalone_i <= 1'b1;
	send(8'h1F, 8'h02, 8'h00, 0);
	standalone_i <= 1'b0;
endtask
task automatic finish_test();
	$display("comparisons %0d mismatches %0d", comparisons, bad_count);
	if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
	else $display("CHECKS NOT OK");
	$finish;
endtask
// Whole run is near 1250 cycles; the 20000-cycle limit means a hang
initial begin
	#2000000;
	bad_count++;
	finish_test();
end
initial begin
	repeat (10) @(posedge clock_i);
	rst_i <= 1'b0;
	v = rnd();
	send(8'h1E, 8'h07, 8'h00, v);
	send(8'h1F, 8'h07, 8'h00, 0);
	chk(rr.value, v);
	chk(accu_o, 0);
	p = rnd();
	actual_pos_i <= p;
	send(8'h20, 8'h00, 8'h00, 0);
	chk({rr.status, rr.value}, {8'h64, p});
	send(8'h1F, 8'h00, 8'h00, 0);
	chk(rr.value, p);
	$display("done get and capture");
	for (int t = 0; t < 11; t++) begin
		a = (t == 4) ? 32'hFFFFFF9C : rnd();
		x = rnd() | 32'h1;
		lda(x);
		send(8'h21, 8'h09, 8'h00, 0);
		lda(a);
		send(8'h21, 8'(t), 8'h00, 0);
		e = calc(t, a, x);
		chk(accu_o, e[63:32]);
		send(8'h21, 8'h0A, 8'h00, 0);
		chk(accu_o, e[31:0]);
	end
	$display("done calc");
	send(8'h27, 8'h14, 8'h00, 0);
	send(8'h1F, 8'h14, 8'h00, 0);
	chk(rr.value, e[31:0]);
	v = rnd();
	send(8'h22, v[7:0], 8'h00, 0);
	chk({aw, ap, rr.status, rr.instr}, {1'b1, v[7:0], 8'h64, 8'h22});
	send(8'h22, 8'h01, 8'h00, 0, 8'h01);
	chk({aw, rr.status}, {1'b0, 8'h01});
	$display("done accu moves");
	send(8'h1F, 8'h15, 8'h00, 0);
	chk({rr.status, rr.instr}, {8'h03, 8'h1F});
	send(8'h21, 8'h0B, 8'h00, 0);
	chk({rr.status, rr.instr}, {8'h03, 8'h21});
	send(8'h1E, 8'h03, 8'hFF, 0);
	chk(rr.status, 8'h04);
	send(8'h30, 8'h00, 8'h00, 0);
	chk({rr.status, rr.instr}, {8'h02, 8'h30});
	$display("done refusals");
	store_nv_i <= 1'b1;
	send(8'h1E, 8'h05, 8'h00, v);
	send(8'h1E, 8'h00, 8'h00, v);
	store_nv_i <= 1'b0;
	send(8'h1E, 8'h05, 8'h00, ~v);
	chk(i_nv_store_model.mem[5], v);
	chk(i_nv_store_model.mem[0], 32'hA5000000);
	send(8'h1F, 8'h05, 8'hFF, 0);
	send(8'h1F, 8'h05, 8'h00, 0);
	chk(rr.value, v);
	send(8'h1F, 8'h00, 8'hFF, 0);
	send(8'h1F, 8'h14, 8'h00, 0);
	chk(rr.value, 32'hA5000014);
	send(8'h1F, 8'h00, 8'h00, 0);
	chk(rr.value, v);
	$display("done storage");
	finish_test();
end
endmodule
`default_nettype wire
